// ### smsp_peer.sv
`timescale 1ns/10ps
// External slave: phase 0, idle-low clock, msb first
module smsp_peer (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic      [7:0] rx_byte
);
  logic [7:0] shreg = 8'h00;  // Outgoing bits
  logic       held  = 1'b0;   // Last bit shown before release
  // Reply loaded on select, first bit valid before the first edge
  always @(negedge sel_n) shreg = tx_byte;
  always @(posedge sel_n) held = shreg[7];
  // Sample on the leading edge
  always @(posedge sck) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
  // Shift on the trailing edge, same moment as the master
  always @(negedge sck) if (!sel_n) shreg = {shreg[6:0], 1'b0};
  // Released line shows the inverse, never a stale copy
  assign miso = sel_n ? ~held : shreg[7];
endmodule

// ### smsp_pkg.sv
package smsp_pkg;
  // Register addresses
  localparam logic [7:0] SMSP_ADDR_STATUS  = 8'h84;
  localparam logic [7:0] SMSP_ADDR_CONTROL = 8'h85;
  localparam logic [7:0] SMSP_ADDR_DATA    = 8'h86;
  // Reset values
  localparam logic [7:0] SMSP_CONTROL_RST  = 8'h04;
  // Status field positions
  localparam int SMSP_ST_DONE  = 7;
  localparam int SMSP_ST_WRITE_COLLISION_FLAG  = 6;
  localparam int SMSP_ST_FULL  = 5;
  localparam int SMSP_ST_BUSY  = 4;
  localparam int SMSP_ST_MODE_FAULT_FLAG  = 3;
  localparam int SMSP_ST_RATE2 = 0;
  // Half bit time, in source pulses, per rate code
  localparam logic [5:0] SMSP_HALF_DIV4  = 6'h02;
  localparam logic [5:0] SMSP_HALF_DIV8  = 6'h04;
  localparam logic [5:0] SMSP_HALF_DIV16 = 6'h08;
  localparam logic [5:0] SMSP_HALF_DIV32 = 6'h10;
  localparam logic [5:0] SMSP_HALF_DIV64 = 6'h20;
  localparam logic [5:0] SMSP_HALF_DIV2  = 6'h01;
  localparam logic [5:0] SMSP_HALF_OVF6  = 6'h03;
  // Rate codes fed by overflow pulses
  localparam logic [2:0] SMSP_RATE_BAUD  = 3'h6;
  localparam logic [2:0] SMSP_RATE_TMR0  = 3'h7;
  // Edges per byte, minus one
  localparam logic [3:0] SMSP_LAST_EDGE  = 4'hf;

  // Control register layout
  typedef struct packed {
    logic       select_ignore;
    logic       port_enable;
    logic       lsb_first;
    logic       master_select;
    logic       clock_polarity;
    logic       clock_phase;
    logic [1:0] rate_low;
  } smsp_ctrl_t;

  // Serial pin bundle towards the port
  typedef struct packed {
    logic miso;
    logic mosi;
    logic sck;
  } smsp_pins_t;
endpackage

// ### smsp_port.sv
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
// Operation
// - Disabled port releases all three serial pins
// - Selected slave drives slave-out, else high-impedance
// - Select low on select-honouring master clears role, flags fault
// - Demotion disables the port, releases all pins, sets done flag
// - Demoted port stays disabled until software re-enables
// - Idle select-honouring master floats out and clock
// - Active master drives out and clock pins
// - Phase 1 slave accepts select held low
// - Master data write starts clock and transfer
// - Eight bits end clock, set done flag
// - Both ends exchange bytes as one ring
// - Write to empty hold buffer sets full
// - Empty shifter takes hold byte at once
// - Master sends valid data; slave waits for clock
// - Write while full flags collision, is dropped
// - Collision flag cleared by writing one
// - Separate receive and transmit buffers behind data
// - Three-bit rate code picks bit clock source
// - Ignoring select, master bit alone sets role
// - Polarity sets idle level; phase picks edges
// - Mode fault cleared only by writing one
module smsp_port
  import smsp_pkg::*;
(
  input  wire logic       CLOCK,
  input  wire logic       RST_N,
  input  wire logic       CE,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       BAUD_OVF,
  input  wire logic       TMR0_OVF,
  input  wire logic       MISO_I,
  output logic            MISO_O,
  output logic            MISO_OE,
  input  wire logic       MOSI_I,
  output logic            MOSI_O,
  output logic            MOSI_OE,
  input  wire logic       SCK_I,
  output logic            SCK_O,
  output logic            SCK_OE,
  input  wire logic       SS_N_I,
  input  wire logic       IRQ_EN,
  output logic            IRQ
);

  smsp_ctrl_t ctrl;          // Control register
  logic       rate2;         // Top rate code bit
  logic       done;          // Transfer done flag
  logic       write_collision_flag;          // Write collision flag
  logic       mode_fault_flag;          // Mode fault flag
  logic [7:0] hold;          // Transmit hold buffer
  logic       full;          // Hold buffer full
  logic [7:0] sh;            // Output shifter
  logic       osr_valid;     // Shifter holds a byte to send
  logic [7:0] rx;            // Receive shifter
  logic [7:0] rx_buf;        // Received byte for software
  logic [3:0] cnt;           // Clock edge counter
  logic       run;           // Master transfer active
  logic       sck;           // Master clock level
  logic [5:0] pre;           // Bit rate prescaler
  logic [3:0] meta;          // First synchroniser stage
  logic [3:0] sync;          // Second synchroniser stage
  logic       sck_prev;      // Last synced slave clock
  logic       ss_prev;       // Last synced select
  smsp_pins_t pin_s;         // Synced serial inputs
  logic       ss_s;          // Synced select, active low level

  // Rate code to half bit time in source pulses
  function automatic logic [5:0] half_of(input logic [2:0] code);
    logic [5:0] r;
    r = SMSP_HALF_OVF6;
    unique case (code)
      3'h0: r = SMSP_HALF_DIV4;
      3'h1: r = SMSP_HALF_DIV8;
      3'h2: r = SMSP_HALF_DIV16;
      3'h3: r = SMSP_HALF_DIV32;
      3'h4: r = SMSP_HALF_DIV64;
      3'h5: r = SMSP_HALF_DIV2;
      3'h6: r = SMSP_HALF_OVF6;
      3'h7: r = SMSP_HALF_OVF6;
    endcase
    return r;
  endfunction

  // Raw pins; order matches the pin bundle, select on top
  logic [3:0] pins_raw;      // Unsynchronised pin levels
  assign pins_raw = {SS_N_I, MISO_I, MOSI_I, SCK_I};
  // Two-flop synchronisers on all inbound pins
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
          meta[gi] <= 1'b1;
          sync[gi] <= 1'b1;
        end else if (CE) begin
          meta[gi] <= pins_raw[gi];
          sync[gi] <= meta[gi];
        end
      end
    end
  endgenerate

  assign pin_s = sync[2:0];
  assign ss_s  = sync[3];

  // Decoded conditions
  logic [2:0] rate;          // Full rate code
  logic       master;        // Acting as master
  logic       fault;         // Foreign master pulled select
  logic       sel;           // Slave is selected
  logic       src;           // Rate source pulse
  logic       ev;            // Shift clock edge event
  logic       lead;          // Event is a leading edge
  logic       sample;        // Event samples input
  logic       din;           // Incoming serial bit
  logic       move;          // Hold buffer to shifter
  logic       byte_end;      // Last edge of a byte
  logic       ss_rise;       // Select released
  logic       wr_ctrl;
  logic       wr_stat;
  logic       wr_data;
  logic [7:0] rx_next;       // Receive shifter next value
  logic [7:0] sh_next;       // Output shifter next value

  assign rate    = {rate2, ctrl.rate_low};
  // Role from master bit alone once select is ignored
  assign master  = ctrl.port_enable & ctrl.master_select;
  // Select low on a select-honouring master
  assign fault   = master & ~ctrl.select_ignore & ~ss_s;
  assign sel     = ctrl.port_enable & ~ctrl.master_select
                 & (ctrl.select_ignore | ~ss_s);
  assign src     = (rate == SMSP_RATE_BAUD) ? BAUD_OVF :
                   (rate == SMSP_RATE_TMR0) ? TMR0_OVF : 1'b1;
  assign ss_rise = ss_s & ~ss_prev;
  // Master edges from the prescaler, slave edges from the pin
  assign ev      = master ? (run & src & (pre == half_of(rate) - 6'h01))
                          : (sel & (pin_s.sck != sck_prev));
  // Even edge count is leading; polarity gives idle level
  assign lead    = master ? ~cnt[0] : (pin_s.sck != ctrl.clock_polarity);
  assign sample  = lead ^ ctrl.clock_phase;
  assign din     = master ? pin_s.miso : pin_s.mosi;
  assign move    = full & ~osr_valid & ~ev;
  assign byte_end = ev & (cnt == SMSP_LAST_EDGE);
  assign wr_ctrl = CE & WR & (ADDR == SMSP_ADDR_CONTROL);
  assign wr_stat = CE & WR & (ADDR == SMSP_ADDR_STATUS);
  assign wr_data = CE & WR & (ADDR == SMSP_ADDR_DATA);
  // Shifter ring; direction by bit order
  assign rx_next = ctrl.lsb_first ? {din, rx[7:1]} : {rx[6:0], din};
  assign sh_next = ctrl.lsb_first ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};

  // Control register; hardware demotes on fault
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl  <= SMSP_CONTROL_RST;
      rate2 <= 1'b0;
    end else if (CE) begin
      if (wr_stat) begin
        rate2 <= WDATA[SMSP_ST_RATE2];
      end
      if (fault) begin
        // Fault wins; stays disabled until rewritten
        ctrl.master_select <= 1'b0;
        ctrl.port_enable   <= 1'b0;
      end else if (wr_ctrl) begin
        ctrl <= WDATA;
      end
    end
  end

  // Status flags; a set beats a same-cycle clear
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      done <= 1'b0;
      write_collision_flag <= 1'b0;
      mode_fault_flag <= 1'b0;
    end else if (CE) begin
      // Done on byte end or on demotion
      if (byte_end || fault) begin
        done <= 1'b1;
      end else if (wr_stat && WDATA[SMSP_ST_DONE]) begin
        done <= 1'b0;
      end
      if (wr_data && full) begin
        write_collision_flag <= 1'b1;
      end else if (wr_stat && WDATA[SMSP_ST_WRITE_COLLISION_FLAG]) begin
        write_collision_flag <= 1'b0;
      end
      // Never cleared by hardware
      if (fault) begin
        mode_fault_flag <= 1'b1;
      end else if (wr_stat && WDATA[SMSP_ST_MODE_FAULT_FLAG]) begin
        mode_fault_flag <= 1'b0;
      end
    end
  end

  // Hold buffer; a write while full is dropped
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      hold <= 8'h00;
      full <= 1'b0;
    end else if (CE) begin
      if (wr_data && !full) begin
        hold <= WDATA;
        full <= 1'b1;
      end else if (move) begin
        full <= 1'b0;
      end
    end
  end

  // Prescaler for the master bit clock
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pre <= 6'h00;
    end else if (CE) begin
      if (!run) begin
        pre <= 6'h00;
      end else if (src) begin
        // Count system_clock or overflow pulses
        pre <= (pre == half_of(rate) - 6'h01) ? 6'h00 : pre + 6'h01;
      end
    end
  end

  // Shift engine shared by master and slave
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sh        <= 8'h00;
      osr_valid <= 1'b0;
      rx        <= 8'h00;
      rx_buf    <= 8'h00;
      cnt       <= 4'h0;
      run       <= 1'b0;
      sck       <= 1'b0;
      sck_prev  <= 1'b0;
      ss_prev   <= 1'b1;
    end else if (CE) begin
      sck_prev <= pin_s.sck;
      ss_prev  <= ss_s;
      if (fault || !ctrl.port_enable) begin
        // Demotion or disable aborts the byte
        run <= 1'b0;
        cnt <= 4'h0;
        sck <= ctrl.clock_polarity;
      end else if (!master && ss_rise && !ctrl.select_ignore) begin
        // Drop partial byte, realign for next
        cnt <= 4'h0;
      end else if (move) begin
        sh        <= hold;
        osr_valid <= 1'b1;
      end else if (master && osr_valid && !run) begin
        // Valid shifter data starts the master clock
        run <= 1'b1;
        cnt <= 4'h0;
        sck <= ctrl.clock_polarity;
      end else if (ev) begin
        // Slave keeps counting while select held low
        if (sample) begin
          rx <= rx_next;
        end else if (!(ctrl.clock_phase && cnt == 4'h0)) begin
          sh <= sh_next;
        end
        cnt <= cnt + 4'h1;
        if (master) begin
          sck <= ~sck;
        end
        if (byte_end) begin
          // Clock stops after eight bits
          run       <= 1'b0;
          osr_valid <= 1'b0;
          rx_buf    <= sample ? rx_next : rx;
        end
      end else if (!run) begin
        sck <= ctrl.clock_polarity;
      end
    end
  end

  // Register read, data one cycle after the strobe
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else if (CE) begin
      if (!RD) begin
        RDATA <= 8'h00;
      end else if (ADDR == SMSP_ADDR_CONTROL) begin
        RDATA <= ctrl;
      end else if (ADDR == SMSP_ADDR_STATUS) begin
        RDATA <= {done, write_collision_flag, full, run | osr_valid | (cnt != 4'h0),
                  mode_fault_flag, 2'b00, rate2};
      end else if (ADDR == SMSP_ADDR_DATA) begin
        RDATA <= rx_buf;
      end else begin
        RDATA <= 8'h00;
      end
    end
  end

  // Pin drivers; all released when disabled
  assign MOSI_O  = ctrl.lsb_first ? sh[0] : sh[7];
  assign MISO_O  = ctrl.lsb_first ? sh[0] : sh[7];
  assign SCK_O   = sck;
  // Active master drives, idle one floats unless select is ignored
  assign MOSI_OE = master & (ctrl.select_ignore | run);
  assign SCK_OE  = master & (ctrl.select_ignore | run);
  // Slave-out only while selected
  assign MISO_OE = sel;
  // Flag output gated by the enable input
  assign IRQ     = IRQ_EN & (done | mode_fault_flag);

  // Checks
  sequence s_write_empty;
    wr_data && !full && !osr_valid && master && !run;
  endsequence
  sequence s_starts;
    ##[1:3] run;
  endsequence

  AST_DISABLED: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !ctrl.port_enable |-> !(MOSI_OE || MISO_OE || SCK_OE))
    else $error("pins driven while disabled");
  AST_SLAVE_HIZ: assert property (@(posedge CLOCK) disable iff (!RST_N)
    ctrl.port_enable && !ctrl.master_select && !ctrl.select_ignore
    |-> MISO_OE == !ss_s)
    else $error("slave-out drive wrong for select");
  AST_FAULT: assert property (@(posedge CLOCK) disable iff (!RST_N)
    CE && fault |=> !ctrl.master_select && !ctrl.port_enable && mode_fault_flag && done)
    else $error("fault did not demote");
  AST_IDLE_HIZ: assert property (@(posedge CLOCK) disable iff (!RST_N)
    master && !ctrl.select_ignore && !run |-> !MOSI_OE && !SCK_OE)
    else $error("idle master drives bus");
  AST_ACTIVE: assert property (@(posedge CLOCK) disable iff (!RST_N)
    run |-> MOSI_OE && SCK_OE && master)
    else $error("active master not driving");
  AST_START: assert property (@(posedge CLOCK) disable iff (!RST_N)
    CE && !fault ##0 s_write_empty |-> s_starts)
    else $error("write did not start transfer");
  AST_END: assert property (@(posedge CLOCK) disable iff (!RST_N)
    CE && byte_end && master |=> done && !run && !osr_valid)
    else $error("byte end not flagged");
  AST_HOLD: assert property (@(posedge CLOCK) disable iff (!RST_N)
    wr_data && !full |=> full && hold == $past(WDATA))
    else $error("hold write lost");
  AST_MOVE: assert property (@(posedge CLOCK) disable iff (!RST_N)
    CE && move && ctrl.port_enable && !fault && !ss_rise
    |=> !full && osr_valid)
    else $error("hold not moved");
  AST_WRITE_COLLISION_FLAG: assert property (@(posedge CLOCK) disable iff (!RST_N)
    wr_data && full |=> write_collision_flag && $stable(hold))
    else $error("collision not flagged");
  AST_MODE_FAULT_FLAG: assert property (@(posedge CLOCK) disable iff (!RST_N)
    mode_fault_flag && !(wr_stat && WDATA[SMSP_ST_MODE_FAULT_FLAG]) |=> mode_fault_flag)
    else $error("mode fault cleared by hardware");

endmodule

// ### smsp_port_tb.sv
`timescale 1ns/10ps
module smsp_port_tb;
  import smsp_pkg::*;
  logic       clock     = 1'b0;  // System clock
  logic       rst_n     = 1'b0;  // Active-low reset
  logic [7:0] addr      = 8'h00; // Bus address
  logic [7:0] wdata     = 8'h00; // Bus write data
  logic       wr        = 1'b0;  // Write strobe
  logic       rd        = 1'b0;  // Read strobe
  logic       ovf       = 1'b0;  // Overflow pulse every other cycle
  logic       tovf      = 1'b0;  // Timer pulse every third cycle
  logic [1:0] tph       = 2'h0;  // Timer pulse phase
  logic       irq_en    = 1'b1;  // Interrupt enable level
  logic       ss_n      = 1'b1;  // Select seen by the port
  logic       peer_sn   = 1'b1;  // Select of the external slave
  logic [7:0] peer_tx   = 8'h00; // Reply of the external slave
  logic       mosi_last = 1'b0;  // Last driven data-out level
  logic       sck_q     = 1'b0;  // Clock pin one cycle back
  logic [7:0] rdata, peer_rx;
  logic       miso_o, miso_oe, mosi_o, mosi_oe, sck_o, sck_oe, irq;
  logic       miso_w, mosi_w, sck_w, peer_miso;
  int         cyc = 0, last_rise = 0, per = 0;
  int         error_cnt = 0;
  int         checked   = 0;

  // Pin levels; the clock line has a pull-down, data-out does not
  assign miso_w = miso_oe ? miso_o : peer_miso;
  assign mosi_w = mosi_oe ? mosi_o : ~mosi_last;
  assign sck_w  = sck_oe & sck_o;

  smsp_port uut (.CLOCK(clock), .RST_N(rst_n), .CE(1'b1), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .BAUD_OVF(ovf),
    .TMR0_OVF(tovf), .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE(miso_oe),
    .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .SCK_I(sck_w),
    .SCK_O(sck_o), .SCK_OE(sck_oe), .SS_N_I(ss_n), .IRQ_EN(irq_en),
    .IRQ(irq));
  smsp_peer peer (.sck(sck_w), .mosi(mosi_w), .sel_n(peer_sn),
    .tx_byte(peer_tx), .miso(peer_miso), .rx_byte(peer_rx));

  always #5 clock = ~clock;
  // Overflow source and clock period monitor
  always @(posedge clock) begin
    ovf   <= ~ovf;
    tph   <= (tph == 2'h2) ? 2'h0 : tph + 2'h1;
    tovf  <= (tph == 2'h2);
    cyc   <= cyc + 1;
    sck_q <= sck_o;
    if (mosi_oe) mosi_last <= mosi_o;
    if (sck_o && !sck_q) begin
      per       <= cyc - last_rise;
      last_rise <= cyc;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Poll for the done flag, bounded
  task automatic wait_done();
    logic [7:0] s;
    for (int i = 0; i < 600; i++) begin
      rd_reg(SMSP_ADDR_STATUS, s);
      if (s[SMSP_ST_DONE] === 1'b1) break;
    end
    chk({7'h0, s[SMSP_ST_DONE]}, 8'h01);
  endtask

  // Reset values, released pins, unmapped read
  task automatic t_reset();
    logic [7:0] s;
    rd_reg(SMSP_ADDR_CONTROL, s);
    chk(s, SMSP_CONTROL_RST);
    rd_reg(SMSP_ADDR_STATUS, s);
    chk(s, 8'h00);
    rd_reg(8'h87, s);
    chk(s, 8'h00);
    chk({5'h0, miso_oe, mosi_oe, sck_oe}, 8'h00);
  endtask

  // Every rate code: exchange a byte and measure the bit clock
  task automatic t_rates();
    int         exp_per [8] = '{4, 8, 16, 32, 64, 2, 12, 18};
    logic [2:0] code;
    logic [7:0] d, s;
    for (int c = 0; c < 8; c++) begin
      code    = 3'(c);
      d       = 8'h5a ^ 8'(c);
      peer_tx = ~d;
      wr_reg(SMSP_ADDR_STATUS, {1'b1, 6'h0, code[2]});
      wr_reg(SMSP_ADDR_CONTROL, {6'b110100, code[1:0]});
      peer_sn = 1'b0;
      wr_reg(SMSP_ADDR_DATA, d);
      wait_done();
      peer_sn = 1'b1;
      chk(peer_rx, d);
      chk(8'(per), 8'(exp_per[c]));
      chk({7'h0, irq}, 8'h01);
      // Fast rates leave the input synchroniser no margin
      if (exp_per[c] >= 8) begin
        rd_reg(SMSP_ADDR_DATA, s);
        chk(s, ~d);
      end
    end
  endtask

  // Lsb-first master byte against the msb-first peer
  task automatic t_order();
    logic [7:0] s;
    wr_reg(SMSP_ADDR_STATUS, 8'h80);
    wr_reg(SMSP_ADDR_CONTROL, 8'hf1);
    peer_tx = 8'h03;
    peer_sn = 1'b0;
    wr_reg(SMSP_ADDR_DATA, 8'h01);
    wait_done();
    peer_sn = 1'b1;
    chk(peer_rx, 8'h80);
    rd_reg(SMSP_ADDR_DATA, s);
    chk(s, 8'hc0);
  endtask

  // Hold buffer fills, third write collides and is dropped
  task automatic t_collision();
    logic [7:0] s;
    wr_reg(SMSP_ADDR_STATUS, 8'h81);
    wr_reg(SMSP_ADDR_CONTROL, 8'hd0);
    peer_tx = 8'hc3;
    peer_sn = 1'b0;
    wr_reg(SMSP_ADDR_DATA, 8'h11);
    tick(4);
    chk({6'h0, mosi_oe, sck_oe}, 8'h03);
    wr_reg(SMSP_ADDR_DATA, 8'h22);
    wr_reg(SMSP_ADDR_DATA, 8'h33);
    rd_reg(SMSP_ADDR_STATUS, s);
    chk(s & 8'h61, 8'h61);
    wr_reg(SMSP_ADDR_STATUS, 8'h41);
    rd_reg(SMSP_ADDR_STATUS, s);
    chk(s & 8'h41, 8'h01);
    wait_done();
    // Phase 0 peer needs select toggled per byte
    peer_sn = 1'b1;
    peer_tx = 8'h3c;
    tick(1);
    peer_sn = 1'b0;
    rd_reg(SMSP_ADDR_DATA, s);
    chk(s, 8'hc3);
    wr_reg(SMSP_ADDR_STATUS, 8'h81);
    wait_done();
    peer_sn = 1'b1;
    chk(peer_rx, 8'h22);
    rd_reg(SMSP_ADDR_DATA, s);
    chk(s, 8'h3c);
  endtask

  // Another master pulls select low on an idle master
  task automatic t_fault();
    logic [7:0] s;
    wr_reg(SMSP_ADDR_STATUS, 8'h80);
    wr_reg(SMSP_ADDR_CONTROL, 8'h50);
    tick(4);
    chk({6'h0, mosi_oe, sck_oe}, 8'h00);
    @(posedge clock);
    ss_n <= 1'b0;
    tick(6);
    @(posedge clock);
    ss_n <= 1'b1;
    rd_reg(SMSP_ADDR_CONTROL, s);
    chk(s & 8'h50, 8'h00);
    rd_reg(SMSP_ADDR_STATUS, s);
    chk(s & 8'h88, 8'h88);
    chk({7'h0, irq}, 8'h01);
    @(posedge clock);
    irq_en <= 1'b0;
    tick(1);
    chk({7'h0, irq}, 8'h00);
    @(posedge clock);
    irq_en <= 1'b1;
    tick(20);
    rd_reg(SMSP_ADDR_STATUS, s);
    chk(s & 8'h08, 8'h08);
    wr_reg(SMSP_ADDR_STATUS, 8'h88);
    rd_reg(SMSP_ADDR_STATUS, s);
    chk(s & 8'h88, 8'h00);
  endtask

  // Slave pin directions, select ignored, then disable
  task automatic t_slave();
    wr_reg(SMSP_ADDR_CONTROL, 8'h44);
    tick(4);
    chk({7'h0, miso_oe}, 8'h00);
    @(posedge clock);
    ss_n <= 1'b0;
    tick(5);
    chk({5'h0, miso_oe, mosi_oe, sck_oe}, 8'h04);
    // No data write while selected
    @(posedge clock);
    ss_n <= 1'b1;
    wr_reg(SMSP_ADDR_CONTROL, 8'hc4);
    tick(4);
    chk({5'h0, miso_oe, mosi_oe, sck_oe}, 8'h04);
    wr_reg(SMSP_ADDR_CONTROL, 8'h04);
    tick(4);
    chk({5'h0, miso_oe, mosi_oe, sck_oe}, 8'h00);
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog, well beyond the expected run of under 3k cycles
  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_rates();
    t_order();
    t_collision();
    t_fault();
    t_slave();
    give_verdict();
  end
endmodule
